// ### include/sfw_pkg.sv
/*
  Constants and types for the serial flash write-protect block: SPI
  command codes, status and lock field positions, Avalon register map
  and the packed state record of the checker.
  Assumes a single reference clock domain; SPI pins arrive asynchronous.
*/
package sfw_pkg;

  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W     = 24;
  localparam int unsigned SECT_LSB   = 16;
  localparam int unsigned SUB_LSB    = 12;
  localparam int unsigned NUM_SECT   = 128;

  // ---------------------------------------------------------------
  // SPI command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_WREN    = 8'h06;
  localparam logic [7:0] CMD_WRDI    = 8'h04;
  localparam logic [7:0] CMD_WRSR    = 8'h01;
  localparam logic [7:0] CMD_WRLOCK  = 8'hE5;
  localparam logic [7:0] CMD_PROG    = 8'h02;
  localparam logic [7:0] CMD_SECT_ER = 8'hD8;
  localparam logic [7:0] CMD_SUB_ER  = 8'h20;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int unsigned SR_SIZE_LO = 2;
  localparam int unsigned SR_TB      = 5;
  localparam int unsigned SR_SIZE3   = 6;
  localparam int unsigned LK_WLOCK   = 0;
  localparam int unsigned LK_LDOWN   = 1;
  localparam logic        WEL_RST    = 1'b0;
  localparam logic        TB_RST     = 1'b0;
  localparam logic [3:0]  SIZE_RST   = 4'h0;

  // ---------------------------------------------------------------
  // Register map (byte offsets) and status bit positions
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_STATUS    = 4'h0;
  localparam logic [3:0] REG_SECT_SEL  = 4'h4;
  localparam logic [3:0] REG_SECT_LOCK = 4'h8;
  localparam logic [3:0] REG_LAST_OP   = 4'hC;
  localparam int unsigned ST_LAST_OK   = 6;
  localparam int unsigned ST_LAST_REJ  = 7;

  typedef enum logic [1:0] {
    EXEC_PROG = 2'b00,
    EXEC_SECT = 2'b01,
    EXEC_SUB  = 2'b10
  } sfw_exec_t;

  typedef enum logic {
    FR_IDLE  = 1'b0,
    FR_SHIFT = 1'b1
  } sfw_frame_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } sfw_av_req_t;

  typedef struct packed {
    sfw_frame_t         frame;
    logic [2:0]         sync1;
    logic [2:0]         sync2;
    logic [2:0]         prev;
    logic [6:0]         sh;
    logic [2:0]         bitcnt;
    logic [2:0]         bytecnt;
    logic [7:0]         op;
    logic [23:0]        addr;
    logic [7:0]         data;
    logic               wel;
    logic               tb;
    logic [3:0]         prot_size;
    logic [127:0]       wlock;
    logic [127:0]       ldown;
    logic [6:0]         sect_sel;
    logic               last_ok;
    logic               last_rej;
    logic               waitreq;
    logic [31:0]        rdata;
    logic               exec_valid;
    sfw_exec_t          exec_kind;
    logic [23:0]        exec_addr;
    logic               reject;
  } sfw_state_t;

endpackage

// ### src/sfw_prot_map.sv
/*
  Address map and protection decode: sector and subsector of an array
  address, and whether the size field or the write-lock bit guards it.
  Purely combinational; the caller registers what it needs.
*/
module sfw_prot_map
  import sfw_pkg::*;
(
  input  wire logic [23:0]  i_addr,       // Array byte address
  input  wire logic         i_tb,         // Bottom-region select
  input  wire logic [3:0]   i_prot_size,  // Protected size field
  input  wire logic [127:0] i_wlock,      // Sector write-lock bits
  output logic      [6:0]   o_sector,     // 64KB sector index
  output logic      [10:0]  o_subsector,  // 4KB subsector index
  output logic              o_size_prot,  // Guarded by size field
  output logic              o_prot        // Guarded by either means
);

  import sfw_pkg::*;

  logic [7:0] span;

  // Top address bit lies beyond the 8MB array and is ignored
  assign o_sector    = i_addr[SECT_LSB+6:SECT_LSB];
  assign o_subsector = i_addr[SUB_LSB+10:SUB_LSB];

  always_comb begin
    span = 8'h00;
    o_size_prot = 1'b0;
    if (i_prot_size[3]) begin
      o_size_prot = 1'b1;
    end else if (i_prot_size[2:0] != 3'h0) begin
      span = 8'h01 << (i_prot_size[2:0] - 3'h1);
      if (i_tb) begin
        o_size_prot = {1'b0, o_sector} < span;
      end else begin
        o_size_prot = {1'b0, o_sector} >= (8'h80 - span);
      end
    end else begin
      o_size_prot = 1'b0;
    end
  end

  assign o_prot = o_size_prot | i_wlock[o_sector];

endmodule // sfw_prot_map

// ### src/sfw_write_protect.sv
/*
  Write-protect checker of a serial NOR flash. Samples the SPI pins,
  collects opcode, address and data bytes, and at deselect decides
  whether a modifying command may run. Granted program and erase
  requests leave as a one-cycle pulse; the array itself is elsewhere.
  Assumes SPI mode 0 or 3 with data taken on the rising serial clock,
  and a serial clock well below a quarter of i_ref_clk.
*/
// Design decisions made here: the placing of the registers and the Avalon-MM register port.
module sfw_write_protect
  import sfw_pkg::*;
(
  input  wire logic              i_ref_clk,     // Reference clock
  input  wire logic              i_resetn,      // Async reset, low
  input  wire logic              i_spi_sck,     // Serial clock pin
  input  wire logic              i_spi_cs_n,    // Chip select, low
  input  wire logic              i_spi_mosi,    // Serial data in
  input  wire sfw_pkg::sfw_av_req_t i_av,       // Avalon request
  output logic      [31:0]       o_readdata,    // Avalon read data
  output logic                   o_waitrequest, // Avalon wait
  output logic                   o_exec_valid,  // Granted op pulse
  output sfw_pkg::sfw_exec_t     o_exec_kind,   // Granted op kind
  output logic      [23:0]       o_exec_addr,   // Granted op address
  output logic                   o_reject       // Refused op pulse
);

  import sfw_pkg::*;

  sfw_state_t st_q;
  sfw_state_t st_d;

  logic [6:0]  sector;
  logic [10:0] subsector;
  logic        size_prot;
  logic        prot;
  logic        sck_rise;
  logic        cs_rise;
  logic        cs_fall;
  logic        frame_end;
  logic        aligned;
  logic        modify_op;
  logic [7:0]  new_byte;
  logic        av_take;

  // ---------------------------------------------------------------
  // Protection decode
  // ---------------------------------------------------------------
  sfw_prot_map u_map (
    .i_addr      (st_q.addr),
    .i_tb        (st_q.tb),
    .i_prot_size (st_q.prot_size),
    .i_wlock     (st_q.wlock),
    .o_sector    (sector),
    .o_subsector (subsector),
    .o_size_prot (size_prot),
    .o_prot      (prot)
  );

  function automatic logic is_array_op(input logic [7:0] op);
    return (op == CMD_PROG) || (op == CMD_SECT_ER) || (op == CMD_SUB_ER);
  endfunction

  // Index 0 sck, 1 cs_n, 2 mosi; edges seen on the second stage only
  assign sck_rise  = st_q.sync2[0] & ~st_q.prev[0];
  assign cs_rise   = st_q.sync2[1] & ~st_q.prev[1];
  assign cs_fall   = ~st_q.sync2[1] & st_q.prev[1];
  assign frame_end = cs_rise && (st_q.frame == FR_SHIFT);
  assign aligned   = (st_q.bitcnt == 3'h0);
  assign modify_op = is_array_op(st_q.op) || (st_q.op == CMD_WRSR) ||
                     (st_q.op == CMD_WRLOCK);
  assign new_byte  = {st_q.sh, st_q.sync2[2]};
  assign av_take   = (i_av.read | i_av.write) & st_q.waitreq;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.sync1 = {i_spi_mosi, i_spi_cs_n, i_spi_sck};
    st_d.sync2 = st_q.sync1;
    st_d.prev  = st_q.sync2;
    st_d.exec_valid = 1'b0;
    st_d.reject     = 1'b0;

    case (st_q.frame)
      FR_IDLE: begin
        if (cs_fall) begin
          st_d.frame   = FR_SHIFT;
          st_d.bitcnt  = 3'h0;
          st_d.bytecnt = 3'h0;
          st_d.op      = 8'h00;
        end
      end
      FR_SHIFT: begin
        if (cs_rise) begin
          st_d.frame = FR_IDLE;
        end else if (sck_rise) begin
          st_d.sh     = new_byte[6:0];
          st_d.bitcnt = st_q.bitcnt + 3'h1;
          if (st_q.bitcnt == 3'h7) begin
            if (st_q.bytecnt == 3'h0) begin
              st_d.op = new_byte;
            end else if (st_q.bytecnt < 3'h4) begin
              st_d.addr = {st_q.addr[15:0], new_byte};
            end else if (st_q.bytecnt == 3'h4) begin
              st_d.data = new_byte;
            end
            if (st_q.bytecnt != 3'h5) begin
              st_d.bytecnt = st_q.bytecnt + 3'h1;
            end
          end
        end
      end
      default: st_d.frame = FR_IDLE;
    endcase

    // Decision at deselect
    if (frame_end && st_q.bytecnt != 3'h0) begin
      if (!aligned) begin
        st_d.reject = modify_op;
      end else if (st_q.op == CMD_WREN) begin
        st_d.wel = 1'b1;
      end else if (st_q.op == CMD_WRDI) begin
        st_d.wel = 1'b0;
      end else if (modify_op && !st_q.wel) begin
        st_d.reject = 1'b1;
      end else if (st_q.op == CMD_WRSR) begin
        if (st_q.bytecnt >= 3'h2) begin
          st_d.tb        = st_q.addr[SR_TB];
          st_d.prot_size = {st_q.addr[SR_SIZE3],
                            st_q.addr[SR_SIZE_LO+2:SR_SIZE_LO]};
          st_d.wel       = 1'b0;
        end else begin
          st_d.reject = 1'b1;
        end
      end else if (st_q.op == CMD_WRLOCK) begin
        if (st_q.bytecnt < 3'h5 || st_q.ldown[sector]) begin
          st_d.reject = 1'b1;
        end else begin
          st_d.wlock[sector] = st_q.data[LK_WLOCK];
          st_d.ldown[sector] = st_q.data[LK_LDOWN];
          st_d.wel           = 1'b0;
        end
      end else if (is_array_op(st_q.op)) begin
        if (st_q.bytecnt < 3'h4 || prot) begin
          st_d.reject = 1'b1;
        end else begin
          st_d.exec_valid = 1'b1;
          st_d.exec_addr  = st_q.addr;
          st_d.exec_kind  = (st_q.op == CMD_PROG) ? EXEC_PROG :
                            (st_q.op == CMD_SECT_ER) ? EXEC_SECT : EXEC_SUB;
          st_d.wel        = 1'b0;
        end
      end
    end
    if (st_d.exec_valid) begin
      st_d.last_ok  = 1'b1;
      st_d.last_rej = 1'b0;
    end else if (st_d.reject) begin
      st_d.last_ok  = 1'b0;
      st_d.last_rej = 1'b1;
    end

    // Avalon slave: wait one cycle, then answer
    st_d.waitreq = ~av_take;
    if (av_take) begin
      if (i_av.address == REG_STATUS) begin
        st_d.rdata = {24'h0, st_q.last_rej, st_q.last_ok,
                      st_q.prot_size, st_q.tb, st_q.wel};
      end else if (i_av.address == REG_SECT_SEL) begin
        st_d.rdata = {25'h0, st_q.sect_sel};
      end else if (i_av.address == REG_SECT_LOCK) begin
        st_d.rdata = {30'h0, st_q.ldown[st_q.sect_sel],
                      st_q.wlock[st_q.sect_sel]};
      end else if (i_av.address == REG_LAST_OP) begin
        st_d.rdata = {st_q.addr, st_q.op};
      end else begin
        st_d.rdata = 32'h0;
      end
    end
    if (i_av.write && !st_q.waitreq && i_av.address == REG_SECT_SEL &&
        i_av.byteenable[0]) begin
      st_d.sect_sel = i_av.writedata[6:0];
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_q           <= '0;
      st_q.frame     <= FR_IDLE;
      st_q.sync1     <= 3'h2;
      st_q.sync2     <= 3'h2;
      st_q.prev      <= 3'h2;
      st_q.wel       <= WEL_RST;
      st_q.tb        <= TB_RST;
      st_q.prot_size <= SIZE_RST;
      st_q.waitreq   <= 1'b1;
      st_q.exec_kind <= EXEC_PROG;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_readdata    = st_q.rdata;
  assign o_waitrequest = st_q.waitreq;
  assign o_exec_valid  = st_q.exec_valid;
  assign o_exec_kind   = st_q.exec_kind;
  assign o_exec_addr   = st_q.exec_addr;
  assign o_reject      = st_q.reject;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence end_s;
    frame_end && st_q.bytecnt != 3'h0;
  endsequence

  sequence array_end_s;
    end_s ##0 (aligned && is_array_op(st_q.op) && st_q.bytecnt >= 3'h4);
  endsequence

  map_split_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (st_q.addr == 24'h7F0000) |-> (subsector == 11'd2032 && sector == 7'd127))
    else $error("Sector map wrong");
  sub_span_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    subsector[10:4] == sector)
    else $error("Subsector not within sector");
  byte_align_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (end_s ##0 (!aligned && modify_op)) |=> (o_reject && !o_exec_valid))
    else $error("Partial byte not refused");
  wel_set_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (end_s ##0 (aligned && st_q.op == CMD_WREN)) |=> st_q.wel)
    else $error("Write enable latch not set");
  wel_gate_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    o_exec_valid |-> ($past(st_q.wel) && !st_q.wel))
    else $error("Granted without latch");
  wlock_rej_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (array_end_s ##0 (st_q.wel && st_q.wlock[sector])) |=> o_reject)
    else $error("Locked sector not refused");
  ldown_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    ((st_q.wlock ^ $past(st_q.wlock)) & $past(st_q.ldown)) == 128'h0)
    else $error("Frozen lock bit changed");
  lock_cmd_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (st_q.wlock != $past(st_q.wlock)) |->
      ($past(frame_end) && $past(st_q.op) == CMD_WRLOCK))
    else $error("Lock changed outside lock command");
  size_none_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (st_q.prot_size == 4'h0) |-> !size_prot)
    else $error("Zero size field protects");
  top_area_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (!st_q.tb && st_q.prot_size == 4'h7) |-> (size_prot == sector[6]))
    else $error("Upper half wrong");
  bot_area_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (st_q.tb && st_q.prot_size == 4'h1) |-> (size_prot == (sector == 7'd0)))
    else $error("Lowest sector wrong");
  all_area_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    st_q.prot_size[3] |-> size_prot)
    else $error("Full protection missing");
  prot_rej_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (array_end_s ##0 (st_q.wel && prot)) |=> (o_reject && !o_exec_valid))
    else $error("Protected target granted");

endmodule // sfw_write_protect

// ### bench/sfw_spi_host.sv
/*
  SPI host model: sends mode-0 frames, MSB first, on request, paced
  by the bench clock.
  Assumes the bench calls send and leaves a gap between frames.
*/
module sfw_spi_host (
  input  wire logic i_clk,   // Bench reference clock
  output logic      o_sck,   // Serial clock, idles low
  output logic      o_cs_n,  // Chip select, active low
  output logic      o_mosi   // Serial data out
);
  timeunit 1ns;
  timeprecision 1ps;

  // Four reference clocks a half period: 200 ns serial period
  localparam int HALF = 4;

  initial begin
    o_sck  = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b1;
  end

  // Caller sets the clock count; counts not a multiple of 8 break byte framing
  task automatic send(input logic [47:0] f, input int nb);
    @(posedge i_clk);
    o_cs_n <= 1'b0;
    for (int i = 0; i < nb; i++) begin
      o_mosi <= f[47-i];
      repeat (HALF) @(posedge i_clk);
      o_sck <= 1'b1;
      repeat (HALF) @(posedge i_clk);
      o_sck <= 1'b0;
    end
    repeat (HALF) @(posedge i_clk);
    o_cs_n <= 1'b1;
    o_mosi <= ~o_mosi;
  endtask
endmodule // sfw_spi_host

// ### bench/sfw_write_protect_tb.sv
/*
  Self-checking bench of the write-protect checker.
  Assumes the SPI host model and the design package.
*/
module sfw_write_protect_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sfw_pkg::*;

  logic        i_ref_clk;
  logic        i_resetn;
  logic        sck;
  logic        cs_n;
  logic        mosi;
  sfw_av_req_t av;
  logic [31:0] rdata;
  logic        wreq;
  logic        ev;
  logic        rj;
  sfw_exec_t   kind;
  logic [23:0] eaddr;
  int          n_fail;
  int          tests_run;

  sfw_write_protect dut (
    .i_ref_clk     (i_ref_clk),
    .i_resetn      (i_resetn),
    .i_spi_sck     (sck),
    .i_spi_cs_n    (cs_n),
    .i_spi_mosi    (mosi),
    .i_av          (av),
    .o_readdata    (rdata),
    .o_waitrequest (wreq),
    .o_exec_valid  (ev),
    .o_exec_kind   (kind),
    .o_exec_addr   (eaddr),
    .o_reject      (rj)
  );
  sfw_spi_host host (
    .i_clk  (i_ref_clk),
    .o_sck  (sck),
    .o_cs_n (cs_n),
    .o_mosi (mosi)
  );

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic report_and_stop();
    if (n_fail == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic av_xfer(bit is_wr, logic [3:0] a, logic [31:0] d,
                         output logic [31:0] q);
    int t;
    @(posedge i_ref_clk);
    av <= '{read: !is_wr, write: is_wr, address: a, byteenable: 4'hF,
            writedata: d};
    for (t = 0; t < 20; t++) begin
      @(posedge i_ref_clk);
      if (wreq === 1'b0) break;
    end
    q = rdata;
    av <= '0;
    if (t == 20) begin
      n_fail++;
      report_and_stop();
    end
  endtask

  task automatic wr(logic [3:0] a, logic [31:0] d);
    logic [31:0] q;
    av_xfer(1'b1, a, d, q);
  endtask

  // Last-op flags masked out of the status word
  task automatic rd(logic [3:0] a, logic [31:0] e, string nm);
    logic [31:0] q;
    av_xfer(1'b0, a, 32'h0, q);
    if (a == REG_STATUS) q[31:6] = '0;
    check(nm, q, e);
  endtask

  task automatic frame(logic [47:0] f, int nb, bit ok, bit rej);
    logic        s_ok;
    logic        s_rej;
    logic [31:0] k;
    logic [31:0] ek;
    logic [23:0] a;
    s_ok = 1'b0;
    s_rej = 1'b0;
    ek = f[47:40] == CMD_SECT_ER ? 32'h1 : 32'h0;
    if (f[47:40] == CMD_SUB_ER) ek = 32'h2;
    host.send(f, nb);
    repeat (10) begin
      @(posedge i_ref_clk);
      if (ev === 1'b1) begin
        s_ok = 1'b1;
        k = 32'(kind);
        a = eaddr;
      end
      if (rj === 1'b1) s_rej = 1'b1;
    end
    check("exec_valid", 32'(s_ok), 32'(ok));
    check("reject", 32'(s_rej), 32'(rej));
    if (ok) begin
      check("exec_addr", 32'(a), 32'(f[39:16]));
      check("exec_kind", k, ek);
    end
  endtask

  task automatic wren();
    frame({CMD_WREN, 40'h0}, 8, 1'b0, 1'b0);
  endtask

  task automatic arr(logic [7:0] op, logic [6:0] s, bit rej);
    wren();
    frame({op, 1'b0, s, 16'h0, 16'h0}, 32, !rej, rej);
  endtask

  task automatic wrsr(bit tb, logic [3:0] sz);
    wren();
    frame({CMD_WRSR, 1'b0, sz[3], tb, sz[2:0], 2'h0, 32'h0}, 16, 0, 0);
    rd(REG_STATUS, {26'h0, sz, tb, 1'b0}, "status");
  endtask

  task automatic lock(logic [6:0] s, logic [1:0] v, bit rej);
    wren();
    frame({CMD_WRLOCK, 1'b0, s, 16'h0, 6'h0, v, 8'h0}, 40, 1'b0, rej);
  endtask

  task automatic do_reset();
    i_resetn <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    repeat (4) @(posedge i_ref_clk);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    rd(REG_STATUS, 32'h0, "status_rst");
    wr(4'h2, 32'hFFFF_FFFF);
    rd(4'h2, 32'h0, "unmapped");
    wr(REG_SECT_SEL, 32'hFFFF_FF85);
    rd(REG_SECT_SEL, 32'h5, "sect_sel");
    rd(REG_SECT_LOCK, 32'h0, "lock_rst");
  endtask

  task automatic t_latch();
    logic [31:0] q;
    frame({CMD_PROG, 24'h7FF000, 16'h0}, 32, 1'b0, 1'b1);
    wren();
    rd(REG_STATUS, 32'h1, "wel_set");
    frame({CMD_PROG, 24'h7FF000, 8'hA5, 8'h0}, 40, 1'b1, 1'b0);
    rd(REG_STATUS, 32'h0, "wel_clr");
    av_xfer(1'b0, REG_STATUS, 32'h0, q);
    check("last_ok", q, 32'h40);
    rd(REG_LAST_OP, {24'h7FF000, CMD_PROG}, "last_op");
    wren();
    frame({CMD_SUB_ER, 24'h7F0000, 16'h0}, 32, 1'b1, 1'b0);
    wren();
    frame({CMD_PROG, 24'h000100, 16'h0}, 33, 1'b0, 1'b1);
    rd(REG_STATUS, 32'h1, "wel_kept");
    av_xfer(1'b0, REG_STATUS, 32'h0, q);
    check("last_rej", q, 32'h81);
    frame({CMD_SECT_ER, 24'h3F0000, 16'h0}, 32, 1'b1, 1'b0);
    wren();
    frame({CMD_WRDI, 40'h0}, 8, 1'b0, 1'b0);
    rd(REG_STATUS, 32'h0, "wel_off");
  endtask

  task automatic t_size();
    int n;
    int p;
    for (int tb = 0; tb < 2; tb++) begin
      for (int k = 0; k < 8; k++) begin
        n = (k == 0) ? 0 : 1 << (k - 1);
        p = tb ? ((n == 0) ? 0 : n - 1) : 128 - ((n == 0) ? 1 : n);
        wrsr(tb[0], k[3:0]);
        arr(CMD_PROG, p[6:0], n != 0);
        arr(CMD_SUB_ER, tb ? p[6:0] + 7'h1 : p[6:0] - 7'h1, 0);
      end
    end
    wrsr(1'b0, 4'hB);
    arr(CMD_SECT_ER, 7'h0, 1'b1);
    wrsr(1'b1, 4'h8);
    arr(CMD_PROG, 7'h7F, 1'b1);
    wrsr(1'b1, 4'h0);
    arr(CMD_PROG, 7'h0, 1'b0);
  endtask

  task automatic t_lock();
    wr(REG_SECT_SEL, 32'h5);
    lock(7'h5, 2'h1, 1'b0);
    rd(REG_SECT_LOCK, 32'h1, "wlock");
    arr(CMD_PROG, 7'h5, 1'b1);
    lock(7'h5, 2'h3, 1'b0);
    lock(7'h5, 2'h0, 1'b1);
    rd(REG_SECT_LOCK, 32'h3, "ldown");
    arr(CMD_SECT_ER, 7'h6, 1'b0);
    do_reset();
    wr(REG_SECT_SEL, 32'h5);
    rd(REG_SECT_LOCK, 32'h0, "lock_rst2");
    arr(CMD_SUB_ER, 7'h5, 1'b0);
  endtask

  initial begin
    i_ref_clk = 1'b0;
    forever #12.5 i_ref_clk = ~i_ref_clk;
  end

  initial begin
    n_fail = 0;
    tests_run = 0;
    av = '0;
    i_resetn = 1'b0;
    do_reset();
    t_regs();
    t_latch();
    t_size();
    t_lock();
    report_and_stop();
  end
endmodule // sfw_write_protect_tb
